// >>> core/ctbe_defs.vh
`ifndef CTBE_DEFS_VH
`define CTBE_DEFS_VH

// ----------------------------------------------------------------------
// Element word layout
// ----------------------------------------------------------------------
`define CTBE_W0_EXT_ID_BIT 30
`define CTBE_W0_RTR_BIT 29
`define CTBE_W0_ID_MSB 28
`define CTBE_STD_ID_LSB 18
`define CTBE_W1_MARKER_MSB 31
`define CTBE_W1_MARKER_LSB 24
`define CTBE_W1_EVT_STORE_BIT 23
`define CTBE_W1_DLC_MSB 19
`define CTBE_W1_DLC_LSB 16
`define CTBE_PAYLOAD_WORD 2

// ----------------------------------------------------------------------
// Register map (word index on the plain register port)
// ----------------------------------------------------------------------
`define CTBE_ADDR_BUF_CFG 4'h0
`define CTBE_ADDR_ESC 4'h1
`define CTBE_ADDR_CTRL 4'h2
`define CTBE_ADDR_START 4'h3
`define CTBE_ADDR_STATUS 4'h4
`define CTBE_ADDR_HDR0 4'h5
`define CTBE_ADDR_HDR1 4'h6
`define CTBE_ADDR_RAM_ADDR 4'h7
`define CTBE_ADDR_RAM_DATA 4'h8

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTBE_BUF_CFG_DED_LSB 0
`define CTBE_BUF_CFG_FQ_LSB 8
`define CTBE_BUF_CFG_BASE_LSB 16
`define CTBE_BUF_CFG_RESET 32'h0000_0000
`define CTBE_ESC_RESET 3'h0
`define CTBE_CTRL_FD_BIT 0
`define CTBE_MAX_PAYLOAD_BYTES 64

`endif

// >>> core/ctbe_fifo2.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two-entry buffer with valid/ready on both sides.
// ----------------------------------------------------------------------
module ctbe_fifo2 #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg rd_ptr_reg;
  reg wr_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge mclk) begin
    if (srst) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'd1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'd1;
      end
    end
  end
endmodule // ctbe_fifo2

// >>> core/ctbe_tx_element.v
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ctbe_defs.vh"

module ctbe_tx_element #(
  parameter RAM_WORDS = 1024,
  parameter RAM_AW = 10,
  parameter MAX_SLOTS = 32
) (
  input wire mclk,
  input wire srst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg frame_valid,
  output reg frame_extended_id_flag,
  output reg frame_remote,
  output reg frame_fd,
  output reg [28:0] frame_id,
  output reg [3:0] frame_dlc,
  output reg [6:0] frame_bytes,
  output reg [7:0] frame_message_marker,
  output reg frame_event_store_enable,
  output reg frame_dedicated,
  output reg byte_valid,
  output reg [7:0] byte_data,
  output reg byte_last,
  input wire byte_ready
);
  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  function [6:0] dlc_bytes;
    input [3:0] dlc;
    input fd;
    begin
      if (dlc <= 4'd8) begin
        dlc_bytes = {3'h0, dlc};
      end else if (!fd) begin
        dlc_bytes = 7'd8;
      end else begin
        case (dlc)
          4'd9: dlc_bytes = 7'd12;
          4'd10: dlc_bytes = 7'd16;
          4'd11: dlc_bytes = 7'd20;
          4'd12: dlc_bytes = 7'd24;
          4'd13: dlc_bytes = 7'd32;
          4'd14: dlc_bytes = 7'd48;
          default: dlc_bytes = 7'd64;
        endcase
      end
    end
  endfunction

  // Element size code 0..7 gives 8,12,16,20,24,32,48,64 payload bytes.
  function [6:0] esc_bytes;
    input [2:0] esc;
    begin
      case (esc)
        3'd0: esc_bytes = 7'd8;
        3'd1: esc_bytes = 7'd12;
        3'd2: esc_bytes = 7'd16;
        3'd3: esc_bytes = 7'd20;
        3'd4: esc_bytes = 7'd24;
        3'd5: esc_bytes = 7'd32;
        3'd6: esc_bytes = 7'd48;
        default: esc_bytes = 7'd64;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers and message RAM
  // --------------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_HDR0 = 2'd1;
  localparam ST_HDR1 = 2'd2;
  localparam ST_DATA = 2'd3;

  reg [31:0] ram [0:RAM_WORDS-1];
  reg [5:0] dedicated_buffer_count_reg;
  reg [5:0] fifo_queue_size_reg;
  reg [2:0] tx_element_size_config_reg;
  reg fd_operation_enable_reg;
  reg [RAM_AW-1:0] ram_ptr_reg;
  reg [RAM_AW-1:0] base_reg;
  reg [5:0] slot_reg;
  reg [1:0] state_reg;
  reg busy_reg;
  reg slot_err_reg;
  reg [31:0] w0_reg;
  reg [31:0] w1_reg;
  reg [31:0] data_word_reg;
  reg [6:0] byte_idx_reg;
  reg [6:0] nbytes_reg;
  reg [RAM_AW-1:0] rd_addr_reg;
  reg [31:0] ram_q_reg;

  wire [6:0] elem_bytes;
  wire [4:0] elem_words;
  wire [RAM_AW-1:0] elem_start;
  wire [6:0] total_slots;
  wire fd_frame;
  wire [6:0] frame_len;
  wire buf_in_valid;
  wire buf_in_ready;
  wire [8:0] buf_in_data;
  wire buf_out_valid;
  wire [8:0] buf_out_data;
  wire out_pop;

  assign elem_bytes = esc_bytes(tx_element_size_config_reg);
  assign elem_words = elem_bytes[6:2] + 5'd2;
  // Dedicated slots come first, so the slot index alone gives the offset.
  assign elem_start = base_reg + slot_reg * elem_words;
  assign total_slots = {1'b0, dedicated_buffer_count_reg} + {1'b0, fifo_queue_size_reg};
  // Remote frames never go out in FD format.
  assign fd_frame = fd_operation_enable_reg && !w0_reg[`CTBE_W0_RTR_BIT];
  // A remote frame carries a length code but no payload.
  assign frame_len = w0_reg[`CTBE_W0_RTR_BIT] ? 7'd0 :
    dlc_bytes(w1_reg[`CTBE_W1_DLC_MSB:`CTBE_W1_DLC_LSB], fd_frame);

  // --------------------------------------------------------------------
  // Register port and fetch sequencer
  // --------------------------------------------------------------------
  always @(posedge mclk) begin
    ram_q_reg <= ram[rd_addr_reg];
    if (reg_wr && reg_addr == `CTBE_ADDR_RAM_DATA) begin
      ram[ram_ptr_reg] <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      dedicated_buffer_count_reg <= 6'h0;
      fifo_queue_size_reg <= 6'h0;
      tx_element_size_config_reg <= `CTBE_ESC_RESET;
      fd_operation_enable_reg <= 1'b0;
      ram_ptr_reg <= {RAM_AW{1'b0}};
      base_reg <= {RAM_AW{1'b0}};
      slot_reg <= 6'h0;
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      slot_err_reg <= 1'b0;
      w0_reg <= 32'h0;
      w1_reg <= 32'h0;
      data_word_reg <= 32'h0;
      byte_idx_reg <= 7'h0;
      nbytes_reg <= 7'h0;
      rd_addr_reg <= {RAM_AW{1'b0}};
      reg_rdata <= 32'h0;
      frame_valid <= 1'b0;
      frame_extended_id_flag <= 1'b0;
      frame_remote <= 1'b0;
      frame_fd <= 1'b0;
      frame_id <= 29'h0;
      frame_dlc <= 4'h0;
      frame_bytes <= 7'h0;
      frame_message_marker <= 8'h0;
      frame_event_store_enable <= 1'b0;
      frame_dedicated <= 1'b0;
    end else begin
      frame_valid <= 1'b0;
      reg_rdata <= 32'h0;
      if (reg_wr) begin
        case (reg_addr)
          `CTBE_ADDR_BUF_CFG: begin
            dedicated_buffer_count_reg <= reg_wdata[`CTBE_BUF_CFG_DED_LSB+5:`CTBE_BUF_CFG_DED_LSB];
            fifo_queue_size_reg <= reg_wdata[`CTBE_BUF_CFG_FQ_LSB+5:`CTBE_BUF_CFG_FQ_LSB];
            base_reg <= reg_wdata[`CTBE_BUF_CFG_BASE_LSB+RAM_AW-1:`CTBE_BUF_CFG_BASE_LSB];
          end
          `CTBE_ADDR_ESC: tx_element_size_config_reg <= reg_wdata[2:0];
          `CTBE_ADDR_CTRL: fd_operation_enable_reg <= reg_wdata[`CTBE_CTRL_FD_BIT];
          `CTBE_ADDR_RAM_ADDR: ram_ptr_reg <= reg_wdata[RAM_AW-1:0];
          `CTBE_ADDR_RAM_DATA: ram_ptr_reg <= ram_ptr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
          `CTBE_ADDR_START: begin
            // A start while busy or beyond the configured slots is dropped.
            if (!busy_reg && reg_wdata[5:0] < total_slots && total_slots <= MAX_SLOTS) begin
              slot_reg <= reg_wdata[5:0];
              busy_reg <= 1'b1;
              slot_err_reg <= 1'b0;
              state_reg <= ST_HDR0;
            end else begin
              slot_err_reg <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `CTBE_ADDR_BUF_CFG: reg_rdata <= {{(32-`CTBE_BUF_CFG_BASE_LSB-RAM_AW){1'b0}},
            base_reg, 2'h0, fifo_queue_size_reg, 2'h0, dedicated_buffer_count_reg};
          `CTBE_ADDR_ESC: reg_rdata <= {29'h0, tx_element_size_config_reg};
          `CTBE_ADDR_CTRL: reg_rdata <= {31'h0, fd_operation_enable_reg};
          `CTBE_ADDR_STATUS: reg_rdata <= {24'h0, frame_dedicated, slot_err_reg, slot_reg};
          `CTBE_ADDR_HDR0: reg_rdata <= {busy_reg, 31'h0};
          `CTBE_ADDR_HDR1: reg_rdata <= {24'h0, frame_message_marker};
          `CTBE_ADDR_RAM_ADDR: reg_rdata <= {{(32-RAM_AW){1'b0}}, ram_ptr_reg};
          default: reg_rdata <= 32'h0;
        endcase
      end
      case (state_reg)
        ST_HDR0: begin
          rd_addr_reg <= elem_start;
          state_reg <= ST_HDR1;
        end
        ST_HDR1: begin
          rd_addr_reg <= rd_addr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
          state_reg <= ST_DATA;
          byte_idx_reg <= 7'h7f;
        end
        ST_DATA: begin
          if (byte_idx_reg == 7'h7f) begin
            // A word shows up one cycle after its address, so word 0 lands first here.
            if (nbytes_reg == 7'h7f) begin
              w1_reg <= ram_q_reg;
              nbytes_reg <= 7'h0;
              byte_idx_reg <= 7'h7e;
            end else begin
              w0_reg <= ram_q_reg;
              nbytes_reg <= 7'h7f;
            end
            rd_addr_reg <= rd_addr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
          end else if (byte_idx_reg == 7'h7e) begin
            frame_valid <= 1'b1;
            frame_extended_id_flag <= w0_reg[`CTBE_W0_EXT_ID_BIT];
            frame_remote <= w0_reg[`CTBE_W0_RTR_BIT];
            frame_fd <= fd_frame;
            frame_id <= w0_reg[`CTBE_W0_EXT_ID_BIT] ? w0_reg[`CTBE_W0_ID_MSB:0] :
              {18'h0, w0_reg[`CTBE_W0_ID_MSB:`CTBE_STD_ID_LSB]};
            frame_dlc <= w1_reg[`CTBE_W1_DLC_MSB:`CTBE_W1_DLC_LSB];
            frame_bytes <= (frame_len > elem_bytes) ? elem_bytes : frame_len;
            frame_message_marker <= w1_reg[`CTBE_W1_MARKER_MSB:`CTBE_W1_MARKER_LSB];
            frame_event_store_enable <= w1_reg[`CTBE_W1_EVT_STORE_BIT];
            frame_dedicated <= ({1'b0, slot_reg} < {1'b0, dedicated_buffer_count_reg});
            // Payload never reads past the configured element.
            nbytes_reg <= (frame_len > elem_bytes) ? elem_bytes : frame_len;
            // The address already points at word 3, ready for the first word switch.
            data_word_reg <= ram_q_reg;
            byte_idx_reg <= 7'h0;
          end else if (byte_idx_reg >= nbytes_reg) begin
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (buf_in_ready) begin
            byte_idx_reg <= byte_idx_reg + 7'd1;
            if (byte_idx_reg[1:0] == 2'd3) begin
              // Next word was prefetched while this one drained.
              data_word_reg <= ram_q_reg;
              rd_addr_reg <= rd_addr_reg + {{(RAM_AW-1){1'b0}}, 1'b1};
            end
          end
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Payload byte stream through the stall buffer
  // --------------------------------------------------------------------
  assign buf_in_valid = (state_reg == ST_DATA) && (byte_idx_reg < nbytes_reg) &&
    (byte_idx_reg < 7'h7e);
  assign buf_in_data = {(byte_idx_reg + 7'd1 == nbytes_reg),
    data_word_reg[{byte_idx_reg[1:0], 3'b000} +: 8]};
  assign out_pop = !byte_valid || byte_ready;

  ctbe_fifo2 #(.WIDTH(9)) u_buf (
    .mclk(mclk),
    .srst(srst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(out_pop),
    .out_data(buf_out_data)
  );

  always @(posedge mclk) begin
    if (srst) begin
      byte_valid <= 1'b0;
      byte_data <= 8'h0;
      byte_last <= 1'b0;
    end else if (out_pop) begin
      byte_valid <= buf_out_valid;
      byte_data <= buf_out_data[7:0];
      byte_last <= buf_out_data[8] && buf_out_valid;
    end
  end
endmodule // ctbe_tx_element

// >>> tb/ctbe_tx_element_props.sv
`timescale 1ns/1ps
`include "ctbe_defs.vh"
module ctbe_chk (
  input logic mclk,
  input logic srst,
  input logic [3:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic frame_valid,
  input logic frame_extended_id_flag,
  input logic frame_remote,
  input logic frame_fd,
  input logic [28:0] frame_id,
  input logic [3:0] frame_dlc,
  input logic [6:0] frame_bytes,
  input logic byte_valid,
  input logic [7:0] byte_data,
  input logic byte_last,
  input logic byte_ready
);
  logic [2:0] esc_reg;
  logic fd_reg;
  logic [6:0] cnt_reg;
  logic [6:0] want;
  logic [6:0] elem;

  // Element sizes share the coding of the long length codes, so one table serves both.
  function automatic [6:0] plen(input [3:0] d, input f);
    plen = (d <= 8) ? 7'(d) : !f ? 7'h8 : (d < 13) ? 7'(4 * d - 24) : 7'(16 * d - 176);
  endfunction

  always @* begin
    elem = plen({1'b1, esc_reg}, 1'b1);
    want = plen(frame_dlc, frame_fd);
    if (want > elem) begin
      want = elem;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      esc_reg <= 3'h0;
      fd_reg <= 1'b0;
      cnt_reg <= 7'h0;
    end else begin
      if (reg_wr && reg_addr == `CTBE_ADDR_ESC) begin
        esc_reg <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `CTBE_ADDR_CTRL) begin
        fd_reg <= reg_wdata[`CTBE_CTRL_FD_BIT];
      end
      if (frame_valid || (byte_valid && byte_ready && byte_last)) begin
        cnt_reg <= 7'h0;
      end else if (byte_valid && byte_ready) begin
        cnt_reg <= cnt_reg + 7'h1;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  chk_remote_classic: assert property (
    frame_valid && frame_remote |-> !frame_fd && frame_bytes == 7'h0)
    else $error("remote frame not classic or has payload");
  chk_fd_select: assert property (
    frame_valid |-> frame_fd == (fd_reg && !frame_remote))
    else $error("frame format select wrong");
  chk_len_decode: assert property (
    frame_valid && !frame_remote |-> frame_bytes == want)
    else $error("payload length wrong for length code");
  chk_std_id: assert property (
    frame_valid && !frame_extended_id_flag |-> frame_id[28:11] == 18'h0)
    else $error("standard identifier wider than 11 bits");
  chk_frame_pulse: assert property (frame_valid |=> !frame_valid)
    else $error("frame valid longer than one cycle");
  chk_stall_hold: assert property (
    byte_valid && !byte_ready |=> byte_valid && $stable(byte_data) && $stable(byte_last))
    else $error("stalled byte changed or dropped");
  chk_byte_count: assert property (
    byte_valid && byte_ready && byte_last |-> cnt_reg + 7'h1 == frame_bytes)
    else $error("byte count at last byte wrong");
endmodule // ctbe_chk

bind ctbe_tx_element ctbe_chk i_chk (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .frame_valid, .frame_extended_id_flag, .frame_remote, .frame_fd, .frame_id,
  .frame_dlc, .frame_bytes, .byte_valid, .byte_data, .byte_last, .byte_ready);

// >>> tb/ctbe_byte_sink.sv
`timescale 1ns/1ps
// Receiver of the payload stream; slow mode stalls three cycles in four.
module ctbe_byte_sink #(
  parameter int SEED = 7
) (
  input logic mclk,
  input logic srst,
  input logic slow,
  output logic byte_ready
);
  int s = SEED;

  initial byte_ready = 1'b0;
  always @(posedge mclk) begin
    byte_ready <= !srst && (slow ? ($random(s) & 3) == 0 : ($random(s) & 3) != 0);
  end
endmodule // ctbe_byte_sink

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "ctbe_defs.vh"
module testbench;
  logic mclk = 0;
  logic srst = 1;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic slow = 0;
  wire [31:0] reg_rdata;
  wire frame_valid, frame_extended_id_flag, frame_remote, frame_fd, frame_event_store_enable;
  wire [28:0] frame_id;
  wire [3:0] frame_dlc;
  wire [6:0] frame_bytes;
  wire [7:0] frame_message_marker, byte_data;
  wire frame_dedicated, byte_valid, byte_last, byte_ready;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 32'h9eb4734d;
  int cyc = 0;
  logic [52:0] hq[$];
  logic [8:0] bq[$];
  logic [63:0] rq[$];
  logic rd_d = 0;
  logic [63:0] x;
  logic [53:0] h;
  logic [9:0] b;
  logic [31:0] pw[16];
  logic [31:0] w0, w1;

  ctbe_tx_element i_dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frame_valid, .frame_extended_id_flag, .frame_remote, .frame_fd, .frame_id, .frame_dlc,
    .frame_bytes, .frame_message_marker, .frame_event_store_enable, .frame_dedicated,
    .byte_valid, .byte_data, .byte_last, .byte_ready);
  ctbe_byte_sink i_sink (.mclk, .srst, .slow, .byte_ready);

  initial forever #5 mclk = ~mclk;

  task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic results;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      x = rq.size() ? rq.pop_front() : {32'h0, 32'hdead_beef};
      cmp("reg_rdata", x[31:0], reg_rdata & x[63:32]);
    end
    if (frame_valid) begin
      h = hq.size() ? {1'b0, hq.pop_front()} : '1;
      cmp("frame header", h, {1'b0, frame_extended_id_flag, frame_remote, frame_fd, frame_id,
        frame_dlc, frame_bytes, frame_message_marker, frame_event_store_enable,
        frame_dedicated});
    end
    if (byte_valid && byte_ready) begin
      b = bq.size() ? {1'b0, bq.pop_front()} : '1;
      cmp("payload byte", b, {1'b0, byte_last, byte_data});
    end
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------------
  task automatic op(logic w, logic r, logic [3:0] a, logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] e);
    rq.push_back({m, e & m});
    op(0, 1, a, 0);
  endtask

  function automatic int plen(logic [3:0] d, logic f);
    return (d <= 8) ? d : !f ? 8 : (d < 13) ? 4 * d - 24 : 16 * d - 176;
  endfunction

  task automatic send(int slot, int e, logic fd, logic [31:0] a0, logic [31:0] a1);
    int eb;
    int len;
    eb = plen(4'(8 + e), 1);
    len = a0[29] ? 0 : plen(a1[19:16], fd);
    if (len > eb) len = eb;
    op(1, 0, `CTBE_ADDR_RAM_ADDR, 5 + slot * (eb / 4 + 2));
    op(1, 0, `CTBE_ADDR_RAM_DATA, a0);
    op(1, 0, `CTBE_ADDR_RAM_DATA, a1);
    for (int k = 0; k < eb / 4; k++) begin
      pw[k] = $random(seed);
      op(1, 0, `CTBE_ADDR_RAM_DATA, pw[k]);
    end
    for (int k = 0; k < len; k++) bq.push_back({k == len - 1, pw[k / 4][8 * (k % 4) +: 8]});
    hq.push_back({a0[30], a0[29], fd & !a0[29], a0[30] ? a0[28:0] : {18'h0, a0[28:18]},
      a1[19:16], 7'(len), a1[31:24], a1[23], slot < 2});
    op(1, 0, `CTBE_ADDR_START, slot);
    op(0, 0, 0, 0);
    while (hq.size() || bq.size()) @(posedge mclk);
    rd(`CTBE_ADDR_HDR0, 32'h8000_0000, 0);
    rd(`CTBE_ADDR_HDR1, 32'hff, a1[31:24]);
    rd(`CTBE_ADDR_STATUS, 32'hff, {slot < 2, 1'b0, 6'(slot)});
    op(0, 0, 0, 0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 0;
    rd(`CTBE_ADDR_BUF_CFG, '1, `CTBE_BUF_CFG_RESET);
    rd(`CTBE_ADDR_ESC, 32'h7, `CTBE_ESC_RESET);
    rd(`CTBE_ADDR_CTRL, '1, 0);
    rd(4'hf, '1, 0);
    rd(`CTBE_ADDR_RAM_DATA, '1, 0);
    op(1, 0, `CTBE_ADDR_BUF_CFG, 32'h0005_0202);
    op(1, 0, `CTBE_ADDR_START, 4);
    rd(`CTBE_ADDR_STATUS, 32'h40, 32'h40);
    op(0, 0, 0, 0);
    $display("reset, map and slot error test done");
    for (int e = 0; e < 8; e++) begin
      slow <= e[0];
      op(1, 0, `CTBE_ADDR_ESC, e);
      op(1, 0, `CTBE_ADDR_CTRL, e >= 4);
      for (int j = 0; j < 4; j++) begin
        w0 = $random(seed);
        w1 = $random(seed);
        // Size code 4 with length code 15 asks for more bytes than the element holds.
        w1[19:16] = (e == 4 && j == 3) ? 4'hf : 4'(e * 4 + j);
        w0[29] = (j == 1 && !e[0]);
        w0[30] = j[0];
        if (!w0[30]) w0[17:0] = 18'h0;
        send(j, e, e >= 4, w0, w1);
      end
      $display("element size code %0d test done", e);
    end
    results();
  end
endmodule // testbench
